// ---- hdl/pdots_scheduler.sv ----
// Purpose: Master-side scheduler deciding when SYNC and receive-side objects go out.
// Assumes: Frame layer and object dictionary sit outside; all inputs are on sys_clk.
// Notes: Outbound frames pass a two-entry buffer so a stalled frame layer loses nothing.
//
// How it works
// R1: Type 0 sends the receive-side object at once on each data change and never otherwise.
// R2: Type 0 makes the slave hold received data and apply it at the next SYNC.
// R3: Type 0 makes the slave send its transmit-side object only on change plus a SYNC.
// R4: Type 0 transmit-side data is valid in the master the moment it arrives.
// R5: Types 1 to 240 send the receive-side object after every N SYNCs, change or not.
// R6: Types 1 to 240 transmit-side data from the slave is used by the master at once.
// R7: Types 254 and 255 send the receive-side object at once on change, never otherwise.
// R8: Types 254 and 255 make the slave send once per event timer period.
// R9: After an event-driven send the slave stays quiet for the inhibit time.
// R10: With event and inhibit time both zero, slave data is sent on change and valid at once.
// R11: Fast-changing transmit-side values should use a synchronous type to spare the bus.
// R12: The master broadcasts SYNC at a fixed configurable period, 50 ms by default.
// R13: Receive-side objects go master to slave, transmit-side objects slave to master.
// R14: A change is found by comparing data with the copy last sent, refreshed on each send.

`timescale 1ns/100ps
`default_nettype none

module pdots_scheduler
   import pdots_pkg::*;
#(
   parameter logic [PDOTS_SYNC_W-1:0] SYNC_CYCLES = PDOTS_SYNC_W'(PDOTS_SYNC_CYCLES)
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] rxo_type,
   input wire logic [PDOTS_DW-1:0] rxo_data,
   input wire logic tso_valid,
   input wire logic [PDOTS_DW-1:0] tso_in,
   output logic out_valid,
   input wire logic out_ready,
   output pdots_frame_t out_frame,
   output logic sync_tick,
   output logic [PDOTS_DW-1:0] tso_data,
   output logic tso_fresh
);

   pdots_state_t st_ff;
   pdots_state_t nxt_st;
   pdots_mode_t mode;

   logic data_changed;
   logic sync_due;
   logic pop;
   logic fifo_space;
   logic push_sync;
   logic push_rxo;
   logic push;
   logic [1:0] cnt_left;
   pdots_frame_t new_frame;

   // Type decode; reserved codes 241 to 253 send no receive-side object, though SYNC still goes out.
   always_comb begin
      if (rxo_type == PDOTS_TYPE_CHG_SYNC) begin
         mode = PDOTS_MODE_CHG;
      end else if (rxo_type >= PDOTS_TYPE_CYC_MIN && rxo_type <= PDOTS_TYPE_CYC_MAX) begin
         mode = PDOTS_MODE_CYC; // see R11
      end else if (rxo_type == PDOTS_TYPE_EVT_A || rxo_type == PDOTS_TYPE_EVT_B) begin
         mode = PDOTS_MODE_CHG;
      end else begin
         mode = PDOTS_MODE_OFF;
      end
   end

   always_comb begin
      nxt_st = st_ff;

      // The SYNC period counter free-runs so the cycle stays fixed under back-pressure.
      sync_due = (st_ff.sync_timer == SYNC_CYCLES - PDOTS_SYNC_W'(1)); // see R12
      if (sync_due) begin
         nxt_st.sync_timer = '0;
      end else begin
         nxt_st.sync_timer = st_ff.sync_timer + PDOTS_SYNC_W'(1);
      end

      data_changed = (rxo_data != st_ff.last_sent); // see R14

      pop = st_ff.out_valid && out_ready;
      // Space is judged before the pop so the push never depends on out_ready.
      fifo_space = (st_ff.fifo_cnt != 2'h2);

      // SYNC goes first; a late SYNC would skew every slave's apply point.
      push_sync = st_ff.sync_pend && fifo_space; // see R12
      push_rxo = 1'b0;
      if (fifo_space && !push_sync) begin
         case (mode)
            PDOTS_MODE_CHG: begin
               push_rxo = data_changed; // see R1, R7
            end
            PDOTS_MODE_CYC: begin
               push_rxo = st_ff.cyc_pend; // see R5
            end
            PDOTS_MODE_OFF: begin
               push_rxo = 1'b0;
            end
            default: begin
               push_rxo = 1'b0;
            end
         endcase
      end
      push = push_sync || push_rxo;

      // Receive-side objects only ever leave the master on this path.
      if (push_sync) begin
         new_frame.kind = PDOTS_KIND_SYNC;
         new_frame.data = PDOTS_DATA_RESET;
      end else begin
         new_frame.kind = PDOTS_KIND_RXO; // see R13
         new_frame.data = rxo_data;
      end

      if (push_rxo) begin
         nxt_st.last_sent = rxo_data; // see R14
      end

      // A new period beats the clear of the pending flag, so no SYNC is lost.
      if (sync_due) begin
         nxt_st.sync_pend = 1'b1;
      end else if (push_sync) begin
         nxt_st.sync_pend = 1'b0;
      end

      // Count SYNCs actually sent; after the Nth one the object is due.
      if (mode != PDOTS_MODE_CYC) begin
         nxt_st.sync_seen = PDOTS_NSYNC_RESET;
         nxt_st.cyc_pend = 1'b0;
      end else begin
         if (push_rxo) begin
            nxt_st.cyc_pend = 1'b0;
         end
         if (push_sync) begin
            if (st_ff.sync_seen + 8'h01 >= rxo_type) begin
               nxt_st.sync_seen = PDOTS_NSYNC_RESET;
               nxt_st.cyc_pend = 1'b1; // see R5
            end else begin
               nxt_st.sync_seen = st_ff.sync_seen + 8'h01;
            end
         end
      end

      // Two-entry buffer; entry 0 is the output register itself.
      if (pop) begin
         nxt_st.fifo[0] = st_ff.fifo[1];
      end
      cnt_left = st_ff.fifo_cnt - {1'b0, pop};
      if (push) begin
         if (cnt_left == 2'h0) begin
            nxt_st.fifo[0] = new_frame;
         end else begin
            nxt_st.fifo[1] = new_frame;
         end
      end
      nxt_st.fifo_cnt = cnt_left + {1'b0, push};
      nxt_st.out_valid = (nxt_st.fifo_cnt != 2'h0);
      nxt_st.sync_tick = push_sync;

      // Inbound transmit-side data is used as soon as it arrives, in every type.
      nxt_st.tso_fresh = tso_valid; // see R4, R6, R10
      if (tso_valid) begin
         nxt_st.tso_data = tso_in; // see R4, R6, R10
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st_ff.sync_timer <= '0;
         st_ff.sync_seen <= PDOTS_NSYNC_RESET;
         st_ff.sync_pend <= 1'b0;
         st_ff.cyc_pend <= 1'b0;
         st_ff.last_sent <= PDOTS_DATA_RESET;
         st_ff.fifo[0].kind <= PDOTS_KIND_SYNC;
         st_ff.fifo[0].data <= PDOTS_DATA_RESET;
         st_ff.fifo[1].kind <= PDOTS_KIND_SYNC;
         st_ff.fifo[1].data <= PDOTS_DATA_RESET;
         st_ff.fifo_cnt <= PDOTS_CNT_RESET;
         st_ff.out_valid <= 1'b0;
         st_ff.sync_tick <= 1'b0;
         st_ff.tso_data <= PDOTS_DATA_RESET;
         st_ff.tso_fresh <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign out_valid = st_ff.out_valid;
   assign out_frame = st_ff.fifo[0];
   assign sync_tick = st_ff.sync_tick;
   assign tso_data = st_ff.tso_data;
   assign tso_fresh = st_ff.tso_fresh;

endmodule // pdots_scheduler

`default_nettype wire

// ---- hdl/pdots_pkg.sv ----
// Purpose: Shared constants and types of the process data object scheduler.
// Assumes: One 40 MHz system clock.
// Notes: The frame carrier is shared by the scheduler and whatever drives the bus.

package pdots_pkg;

   // Width of one mapped data object.
   localparam int PDOTS_DW = 32;

   // Transmission type codes.
   localparam logic [7:0] PDOTS_TYPE_CHG_SYNC = 8'h00;
   localparam logic [7:0] PDOTS_TYPE_CYC_MIN = 8'h01;
   localparam logic [7:0] PDOTS_TYPE_CYC_MAX = 8'hF0;
   localparam logic [7:0] PDOTS_TYPE_EVT_A = 8'hFE;
   localparam logic [7:0] PDOTS_TYPE_EVT_B = 8'hFF;
   localparam logic [7:0] PDOTS_TYPE_RESET = 8'hFF;

   // SYNC cycle timing.
   localparam int PDOTS_CLK_HZ = 40000000;
   localparam int PDOTS_SYNC_PERIOD_MS = 50;
   localparam int PDOTS_SYNC_CYCLES = PDOTS_SYNC_PERIOD_MS * (PDOTS_CLK_HZ / 1000);
   localparam int PDOTS_SYNC_W = 24;

   // Reset values.
   localparam logic [PDOTS_DW-1:0] PDOTS_DATA_RESET = 32'h0000_0000;
   localparam logic [1:0] PDOTS_CNT_RESET = 2'h0;
   localparam logic [7:0] PDOTS_NSYNC_RESET = 8'h00;

   typedef enum logic [2:0] {
      PDOTS_MODE_CHG = 3'b001,
      PDOTS_MODE_CYC = 3'b010,
      PDOTS_MODE_OFF = 3'b100
   } pdots_mode_t;

   typedef enum logic [1:0] {
      PDOTS_KIND_SYNC = 2'b01,
      PDOTS_KIND_RXO = 2'b10
   } pdots_kind_t;

   typedef struct packed {
      pdots_kind_t kind;
      logic [PDOTS_DW-1:0] data;
   } pdots_frame_t;

   typedef struct packed {
      logic [PDOTS_SYNC_W-1:0] sync_timer;
      logic [7:0] sync_seen;
      logic sync_pend;
      logic cyc_pend;
      logic [PDOTS_DW-1:0] last_sent;
      pdots_frame_t [1:0] fifo;
      logic [1:0] fifo_cnt;
      logic out_valid;
      logic sync_tick;
      logic [PDOTS_DW-1:0] tso_data;
      logic tso_fresh;
   } pdots_state_t;

endpackage

// ---- testbench/pdots_sva.sv ----
// Purpose: Port checks of the object scheduler.
// Assumes: One clock with a synchronous low reset.
// Notes: SYNC spacing allows for short frame layer stalls.
`timescale 1ns/100ps
`default_nettype none
module pdots_sva
   import pdots_pkg::*;
#(parameter logic [PDOTS_SYNC_W-1:0] SYNC_CYCLES = 24'h000014) (
   input wire logic sys_clk, rstn, tso_valid, out_valid, out_ready, sync_tick, tso_fresh,
   input wire logic [7:0] rxo_type,
   input wire logic [PDOTS_DW-1:0] rxo_data, tso_in, tso_data,
   input wire pdots_frame_t out_frame);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_stall; out_valid && !out_ready; endsequence
   AST_FRESH: assert property (tso_valid |=> tso_fresh && tso_data == $past(tso_in))
      else $error("arrival not shown");
   AST_IDLE: assert property (!tso_valid |=> !tso_fresh && $stable(tso_data))
      else $error("stray arrival");
   AST_HOLD: assert property (s_stall |=> out_valid && $stable(out_frame))
      else $error("frame lost in stall");
   AST_KIND: assert property (out_valid |-> out_frame.kind inside {PDOTS_KIND_SYNC, PDOTS_KIND_RXO})
      else $error("bad frame kind");
   AST_ZERO: assert property (out_valid && out_frame.kind == PDOTS_KIND_SYNC |-> out_frame.data == '0)
      else $error("sync data not zero");
   AST_TICK: assert property (sync_tick |-> out_valid ##1 !sync_tick [*8])
      else $error("sync too early");
   AST_GAP: assert property (sync_tick |=> ##[8:30] sync_tick)
      else $error("sync too late");
   AST_CHG: assert property ($changed(rxo_data) && rxo_type == PDOTS_TYPE_CHG_SYNC && !out_valid |-> ##[1:3] out_valid)
      else $error("change not sent");
endmodule // pdots_sva
bind pdots_scheduler pdots_sva #(.SYNC_CYCLES(SYNC_CYCLES)) u_sva (.*);
`default_nettype wire

// ---- testbench/pdots_slave_model.sv ----
// Purpose: Frame layer and slave node facing the scheduler.
// Assumes: The slave answers every SYNC with one transmit-side object.
// Notes: Idle data lines show the inverse of the last word.
`timescale 1ns/100ps
`default_nettype none
module pdots_slave_model
   import pdots_pkg::*;
(
   input wire logic sys_clk, rstn, out_valid,
   input wire pdots_frame_t out_frame,
   output logic out_ready, tso_valid,
   output logic [PDOTS_DW-1:0] tso_in, held,
   output var int n_sync, n_rxo);
   logic [2:0] tick_ff;
   always_ff @(posedge sys_clk) begin
      tick_ff <= rstn ? tick_ff + 3'h1 : 3'h0;
      // Three stalled cycles in eight keep the two-entry buffer filling.
      out_ready <= rstn && tick_ff > 3'h2;
      tso_valid <= 1'b0;
      tso_in <= rstn ? ~tso_in : 32'h0;
      if (!rstn) begin
         n_sync <= 0;
         n_rxo <= 0;
      end else if (out_valid && out_ready && out_frame.kind == PDOTS_KIND_SYNC) begin
         n_sync <= n_sync + 1;
         tso_valid <= 1'b1;
         tso_in <= 32'hA5A5_0000 ^ n_sync;
      end else if (out_valid && out_ready) begin
         n_rxo <= n_rxo + 1;
         held <= out_frame.data;
      end
   end
endmodule // pdots_slave_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench of the object scheduler.
// Assumes: SYNC period cut to 20 cycles to keep the run short.
// Notes: A hang is cut off after 20000 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import pdots_pkg::*;
   logic sys_clk = 1'b0, rstn = 1'b0, tso_valid, out_valid, out_ready, sync_tick, tso_fresh;
   logic [7:0] rxo_type = 8'h00;
   logic [PDOTS_DW-1:0] rxo_data = 32'h0, tso_in, tso_data, held;
   pdots_frame_t out_frame;
   int error_cnt = 0, num_checks = 0, n_sync, n_rxo, r0, s0;
   pdots_scheduler #(.SYNC_CYCLES(24'h000014)) u_dut (.*);
   pdots_slave_model u_slave (.*);
   initial forever #12.5 sys_clk = ~sys_clk;
   task automatic check(input logic [63:0] seen, exp);
      num_checks++;
      if (seen !== exp) error_cnt++;
      if (seen !== exp) $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic wait_sync(input int t);
      for (int i = 0; i < 6000 && n_sync < t; i++) step(1);
   endtask
   task automatic t_change(input logic [7:0] ty, input logic [31:0] d, input int sends);
      rxo_type = ty;
      r0 = n_rxo;
      rxo_data = d;
      step(10);
      check(n_rxo - r0, sends);
      step(50);
      check(n_rxo - r0, sends);
      if (sends > 0) check(held, d);
   endtask
   task automatic t_cyclic(input logic [7:0] n);
      // A reserved type clears the SYNC counter and any pending object left by the last type.
      rxo_type = 8'hF1;
      wait_sync(n_sync + 1);
      step(8);
      rxo_type = n;
      r0 = n_rxo;
      s0 = n_sync;
      wait_sync(s0 + n - 1);
      step(8);
      check(n_rxo - r0, 0);
      wait_sync(s0 + n);
      step(8);
      check(n_rxo - r0, 1);
      check(tso_data, 32'hA5A5_0000 ^ (n_sync - 1));
   endtask
   initial begin
      step(20000);
      error_cnt++;
      summarize();
   end
   initial begin
      step(6);
      rstn = 1'b1;
      t_change(8'h00, 32'h0000_1234, 1);
      t_change(8'hFE, 32'h0000_5678, 1);
      t_change(8'hFF, 32'hFFFF_FFFF, 1);
      t_change(8'hF1, 32'h0000_0001, 0);
      t_cyclic(8'h01);
      t_cyclic(8'h02);
      t_cyclic(8'hF0);
      summarize();
   end
endmodule // tb_top
`default_nettype wire
